// ===== logic/icache_global_control.sv
// global control register of the instruction cache with its control outputs
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module icache_global_control #(
    parameter int LINE_ADDR_W = 24
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [15:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [15:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // core requests
    input wire logic core_cache_enable,
    input wire logic core_cache_clear,
    // per-block local bits from the block control registers
    input wire logic way_local_enable,
    input wire logic ramset1_local_enable,
    input wire logic ramset2_local_enable,
    input wire logic way_local_flush,
    input wire logic ramset1_local_flush,
    input wire logic ramset2_local_flush,
    // activity of the lookup datapath, for automatic gating
    input wire logic cache_active,
    // block enables and configuration
    output logic way_block_enable,
    output logic way_two_way,
    output logic ramset1_enable,
    output logic ramset2_enable,
    output logic miss_word_forward,
    output logic ram_fill_mode,
    // module clock control
    output logic module_clock_enable,
    output logic auto_gate_active,
    // flush pulses
    output logic way_flush,
    output logic ramset1_flush,
    output logic ramset2_flush,
    // line flush handshake
    output logic line_flush_req,
    output logic [LINE_ADDR_W-1:0] line_flush_addr,
    input wire logic line_flush_ack
);
    reg_port_if rp ();

    logic [15:0] ctl_reg;
    logic [15:0] flush_addr_low_reg;
    logic [15:0] flush_addr_high_reg;
    logic [15:0] ctl_next;
    logic [15:0] status_word;
    logic clear_seen_reg;
    logic clear_rise;
    logic line_start;
    logic line_busy;
    logic line_done;
    logic hit_ctl;
    logic hit_fal;
    logic hit_fah;
    logic cache_on;
    logic rs_on;
    logic rs_two;
    logic way_on;

    axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .rp(rp)
    );

    // merge a 16-bit register with the two low byte lanes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // register write decode
    always_comb begin
        hit_ctl = rp.wr_en && (rp.wr_addr == cgc_pkg::CTL_ADDR);
        hit_fal = rp.wr_en && (rp.wr_addr == cgc_pkg::FAL_ADDR);
        hit_fah = rp.wr_en && (rp.wr_addr == cgc_pkg::FAH_ADDR);
        rp.wr_err = rp.wr_en && !(hit_ctl || hit_fal || hit_fah
            || (rp.wr_addr == cgc_pkg::STAT_ADDR));
    end

    assign ctl_next = merge16(ctl_reg, rp.wr_data, rp.wr_strb);
    // bit 13 is stored as written; keeping it zero is software's job
    assign line_start = hit_ctl && ctl_next[cgc_pkg::LINE_FLUSH_BIT];

    // a software set in the done cycle wins over the self-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_reg <= cgc_pkg::CTL_RESET;
        end else if (hit_ctl) begin
            ctl_reg <= ctl_next;
        end else if (line_done) begin
            ctl_reg[cgc_pkg::LINE_FLUSH_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flush_addr_low_reg <= 16'h0000;
        end else if (hit_fal) begin
            flush_addr_low_reg <= merge16(flush_addr_low_reg, rp.wr_data, rp.wr_strb);
        end
    end

    // upper byte of the high half is reserved and reads zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flush_addr_high_reg <= 16'h0000;
        end else if (hit_fah) begin
            flush_addr_high_reg <= merge16(flush_addr_high_reg, rp.wr_data, rp.wr_strb)
                & cgc_pkg::FAH_MASK;
        end
    end

    line_flush_engine #(
        .ADDR_W(LINE_ADDR_W)
    ) u_line_flush (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(line_start),
        .addr(LINE_ADDR_W'({flush_addr_high_reg[7:0], flush_addr_low_reg})),
        .busy(line_busy),
        .done(line_done),
        .line_flush_req(line_flush_req),
        .line_flush_addr(line_flush_addr),
        .line_flush_ack(line_flush_ack)
    );

    // configuration decode; only the supported layouts can be formed
    assign cache_on = core_cache_enable;
    assign way_on = ctl_reg[cgc_pkg::WAY_ON_BIT];
    assign rs_on = ctl_reg[cgc_pkg::RAMSET_ON_BIT];
    // a nonzero count with a clear low bit is treated as one block
    assign rs_two = ctl_reg[cgc_pkg::RS_CNT_LSB];

    // enables follow the core request; global select overrides local bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            way_block_enable <= 1'b0;
            ramset1_enable <= 1'b0;
            ramset2_enable <= 1'b0;
        end else begin
            way_block_enable <= cache_on && way_on
                && (ctl_reg[cgc_pkg::WHOLE_EN_BIT] || way_local_enable);
            ramset1_enable <= cache_on && rs_on
                && (ctl_reg[cgc_pkg::WHOLE_EN_BIT] || ramset1_local_enable);
            ramset2_enable <= cache_on && rs_on && rs_two
                && (ctl_reg[cgc_pkg::WHOLE_EN_BIT] || ramset2_local_enable);
        end
    end

    // way count field: only its low bit matters, two ways at most
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            way_two_way <= 1'b0;
            miss_word_forward <= 1'b0;
            ram_fill_mode <= 1'b0;
        end else begin
            way_two_way <= ctl_reg[cgc_pkg::WAY_CNT_LSB];
            miss_word_forward <= ctl_reg[cgc_pkg::FORWARD_BIT];
            ram_fill_mode <= ctl_reg[cgc_pkg::FILL_MODE_BIT];
        end
    end

    // module clock: runs while enabled, held on when disabled if asked,
    // and with auto gating it only runs while the datapath or a line flush is busy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            module_clock_enable <= 1'b1;
            auto_gate_active <= 1'b0;
        end else begin
            auto_gate_active <= cache_on && ctl_reg[cgc_pkg::AUTO_GATE_BIT];
            if (cache_on) begin
                module_clock_enable <= !ctl_reg[cgc_pkg::AUTO_GATE_BIT]
                    || cache_active || line_busy;
            end else begin
                module_clock_enable <= ctl_reg[cgc_pkg::CLK_HOLD_BIT];
            end
        end
    end

    // clear request is taken on its rising edge, once per request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clear_seen_reg <= 1'b0;
        end else begin
            clear_seen_reg <= core_cache_clear;
        end
    end
    assign clear_rise = core_cache_clear && !clear_seen_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            way_flush <= 1'b0;
            ramset1_flush <= 1'b0;
            ramset2_flush <= 1'b0;
        end else begin
            way_flush <= clear_rise
                && (ctl_reg[cgc_pkg::WHOLE_FLUSH_BIT] || way_local_flush);
            ramset1_flush <= clear_rise
                && (ctl_reg[cgc_pkg::WHOLE_FLUSH_BIT] || ramset1_local_flush);
            ramset2_flush <= clear_rise
                && (ctl_reg[cgc_pkg::WHOLE_FLUSH_BIT] || ramset2_local_flush);
        end
    end

    // status word shows the block's live state
    always_comb begin
        status_word = 16'h0000;
        status_word[cgc_pkg::ST_ENABLED_BIT] = cache_on;
        status_word[cgc_pkg::ST_FLUSH_BUSY_BIT] = line_busy;
        status_word[cgc_pkg::ST_WAY_EN_BIT] = way_block_enable;
        status_word[cgc_pkg::ST_RS1_EN_BIT] = ramset1_enable;
        status_word[cgc_pkg::ST_RS2_EN_BIT] = ramset2_enable;
        status_word[cgc_pkg::ST_TWO_WAY_BIT] = way_two_way;
        status_word[cgc_pkg::ST_CLK_RUN_BIT] = module_clock_enable;
    end

    // read mux; unmapped addresses answer slverr with zero data
    always_comb begin
        rp.rd_data = 32'h0000_0000;
        rp.rd_err = 1'b0;
        unique case (rp.rd_addr)
            cgc_pkg::CTL_ADDR: rp.rd_data = {16'h0000, ctl_reg};
            cgc_pkg::FAL_ADDR: rp.rd_data = {16'h0000, flush_addr_low_reg};
            cgc_pkg::FAH_ADDR: rp.rd_data = {16'h0000, flush_addr_high_reg};
            cgc_pkg::STAT_ADDR: rp.rd_data = {16'h0000, status_word};
            default: rp.rd_err = 1'b1;
        endcase
    end
endmodule
`default_nettype wire

// ===== inc/gcr_pkg.sv
// constants for the cache global control block
package cgc_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] CTL_IDX = 16'h1400;
    localparam logic [15:0] FAL_IDX = 16'h1401;
    localparam logic [15:0] FAH_IDX = 16'h1402;
    localparam logic [15:0] STAT_IDX = 16'h1410;
    localparam logic [15:0] CTL_ADDR = {CTL_IDX[13:0], 2'b00};
    localparam logic [15:0] FAL_ADDR = {FAL_IDX[13:0], 2'b00};
    localparam logic [15:0] FAH_ADDR = {FAH_IDX[13:0], 2'b00};
    localparam logic [15:0] STAT_ADDR = {STAT_IDX[13:0], 2'b00};
    localparam int ADDR_W = 16;
    localparam int REG_W = 16;
    // global control fields
    localparam int CLK_HOLD_BIT = 15;
    localparam int AUTO_GATE_BIT = 14;
    localparam int RSVD_BIT = 13;
    localparam int LINE_FLUSH_BIT = 12;
    localparam int WHOLE_FLUSH_BIT = 11;
    localparam int RAMSET_ON_BIT = 10;
    localparam int WAY_ON_BIT = 9;
    localparam int RS_CNT_LSB = 5;
    localparam int WAY_CNT_LSB = 3;
    localparam int FORWARD_BIT = 2;
    localparam int FILL_MODE_BIT = 1;
    localparam int WHOLE_EN_BIT = 0;
    localparam logic [15:0] CTL_RESET = 16'hC006;
    localparam logic [15:0] FAH_MASK = 16'h00FF;
    // status register fields
    localparam int ST_ENABLED_BIT = 0;
    localparam int ST_FLUSH_BUSY_BIT = 1;
    localparam int ST_WAY_EN_BIT = 2;
    localparam int ST_RS1_EN_BIT = 3;
    localparam int ST_RS2_EN_BIT = 4;
    localparam int ST_TWO_WAY_BIT = 5;
    localparam int ST_CLK_RUN_BIT = 6;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== inc/reg_port_if.sv
// simple register access port between bus slave and register file
`timescale 1ns/1ns
`default_nettype none
interface reg_port_if;
    logic wr_en;
    logic [15:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [15:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    modport bus (output wr_en, output wr_addr, output wr_data, output wr_strb,
        input wr_err, output rd_addr, input rd_data, input rd_err);
    modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb,
        output wr_err, input rd_addr, output rd_data, output rd_err);
endinterface
`default_nettype wire

// ===== logic/axil_slave.sv
// axi4-lite slave front end driving the register port
`timescale 1ns/1ns
`default_nettype none
module axil_slave (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic [15:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read
    input wire logic [15:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // register side
    reg_port_if.bus rp
);
    logic aw_held;
    logic w_held;
    logic [15:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    assign awready = ~aw_held & ~bvalid;
    assign wready = ~w_held & ~bvalid;
    assign arready = ~rvalid;
    // write happens once both halves are held, one cycle before bvalid
    assign rp.wr_en = aw_held & w_held & ~bvalid;
    assign rp.wr_addr = aw_addr_reg;
    assign rp.wr_data = w_data_reg;
    assign rp.wr_strb = w_strb_reg;
    assign rp.rd_addr = araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr_reg <= 16'h0000;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (rp.wr_en) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
        end else if (rp.wr_en) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= cgc_pkg::RESP_OKAY;
        end else if (rp.wr_en) begin
            bvalid <= 1'b1;
            bresp <= rp.wr_err ? cgc_pkg::RESP_SLVERR : cgc_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= cgc_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rp.rd_data;
            rresp <= rp.rd_err ? cgc_pkg::RESP_SLVERR : cgc_pkg::RESP_OKAY;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== logic/line_flush_engine.sv
// hands one line-flush request to the cache and reports completion
`timescale 1ns/1ns
`default_nettype none
module line_flush_engine #(
    parameter int ADDR_W = 24
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic start,
    input wire logic [ADDR_W-1:0] addr,
    output logic busy,
    output logic done,
    // cache side
    output logic line_flush_req,
    output logic [ADDR_W-1:0] line_flush_addr,
    input wire logic line_flush_ack
);
    typedef enum logic [1:0] {
        FL_IDLE = 2'b01,
        FL_REQ = 2'b10
    } fl_state_e;
    fl_state_e state_reg;

    assign busy = (state_reg == FL_REQ);
    assign line_flush_req = busy;

    // start while busy is dropped; the pending bit stays set until done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= FL_IDLE;
            line_flush_addr <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_reg)
                FL_IDLE: begin
                    if (start) begin
                        state_reg <= FL_REQ;
                        line_flush_addr <= addr;
                    end
                end
                FL_REQ: begin
                    if (line_flush_ack) begin
                        state_reg <= FL_IDLE;
                        done <= 1'b1;
                    end
                end
                default: state_reg <= FL_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== sim/icache_gc_assertions.sv
// port assertions for the cache global control block
`timescale 1ns/1ns
`default_nettype none
module icache_gc_assertions #(
    parameter int LINE_ADDR_W = 24
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // read handshake
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    // core side
    input wire logic core_cache_enable,
    input wire logic core_cache_clear,
    input wire logic way_local_flush,
    input wire logic ramset1_local_flush,
    input wire logic cache_active,
    // control outputs
    input wire logic way_block_enable,
    input wire logic auto_gate_active,
    input wire logic module_clock_enable,
    input wire logic way_flush,
    input wire logic ramset1_flush,
    input wire logic ramset2_flush,
    // line flush handshake
    input wire logic line_flush_req,
    input wire logic [LINE_ADDR_W-1:0] line_flush_addr,
    input wire logic line_flush_ack
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_flush_cause: assert property (way_flush |-> $past(core_cache_clear) &&
        !$past(core_cache_clear, 2)) else $error("way flush without a clear edge");
    a_local_way_flush: assert property ($rose(core_cache_clear) && way_local_flush |=>
        way_flush) else $error("local way flush bit ignored");
    a_local_rs1_flush: assert property ($rose(core_cache_clear) ##0 ramset1_local_flush
        |=> ramset1_flush) else $error("local ramset flush bit ignored");
    a_flush_single: assert property (way_flush || ramset2_flush |=>
        !way_flush && !ramset2_flush) else $error("flush pulse too long");
    a_way_needs_core: assert property (way_block_enable |-> core_cache_enable ||
        $past(core_cache_enable) || $past(core_cache_enable, 2))
        else $error("way block enabled without core request");
    a_gate_off_idle: assert property ($fell(core_cache_enable) ##1
        !core_cache_enable [*2] |=> !auto_gate_active) else $error("gating left on");
    a_clock_on_busy: assert property (core_cache_enable [*3] ##0 cache_active |=>
        module_clock_enable) else $error("clock stopped while datapath busy");
    a_line_req_hold: assert property (line_flush_req && !line_flush_ack |=>
        line_flush_req && $stable(line_flush_addr)) else $error("line request dropped");
    a_line_req_drop: assert property (line_flush_req && line_flush_ack |=>
        !line_flush_req) else $error("line request held after ack");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered");

    c_clear: cover property (way_flush && ramset1_flush);
    c_line_flush: cover property (line_flush_req && line_flush_ack);
    c_enabled: cover property (way_block_enable && auto_gate_active);
endmodule

bind icache_global_control icache_gc_assertions #(.LINE_ADDR_W(LINE_ADDR_W)) chk_i (
    .aclk, .aresetn, .arvalid, .arready, .rvalid, .core_cache_enable, .core_cache_clear,
    .way_local_flush, .ramset1_local_flush, .cache_active, .way_block_enable,
    .auto_gate_active, .module_clock_enable, .way_flush, .ramset1_flush, .ramset2_flush,
    .line_flush_req, .line_flush_addr, .line_flush_ack);
`default_nettype wire

// ===== sim/core_model.sv
// behavioural core raising cache enable and clear requests
`timescale 1ns/1ns
`default_nettype none
module core_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench requests
    input wire logic enable_req,
    input wire logic clear_req,
    input wire logic [1:0] lag,
    // core lines
    output logic core_cache_enable,
    output logic core_cache_clear
);
    logic pend_reg;
    logic [1:0] wait_reg;
    // bench raises enable only after programming the register
    always_ff @(posedge aclk) begin
        core_cache_enable <= aresetn && enable_req;
    end
    // one-cycle request, so clear always drops before the next one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_reg <= 1'h0;
            wait_reg <= 2'h0;
            core_cache_clear <= 1'h0;
        end else if (core_cache_clear) begin
            core_cache_clear <= 1'h0;
        end else if (pend_reg) begin
            wait_reg <= wait_reg - 2'h1;
            pend_reg <= wait_reg != 2'h0;
            core_cache_clear <= wait_reg == 2'h0;
        end else if (clear_req) begin
            pend_reg <= 1'h1;
            wait_reg <= lag;
        end
    end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the cache global control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, enable_req, clear_req, cache_active;
    logic core_cache_enable, core_cache_clear, line_flush_req, line_flush_ack;
    logic way_local_enable, ramset1_local_enable, ramset2_local_enable;
    logic way_local_flush, ramset1_local_flush, ramset2_local_flush;
    logic way_block_enable, way_two_way, ramset1_enable, ramset2_enable, miss_word_forward;
    logic ram_fill_mode, module_clock_enable, auto_gate_active;
    logic way_flush, ramset1_flush, ramset2_flush;
    logic [15:0] awaddr, araddr, g_m, m;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, s;
    logic [1:0] bresp, rresp, lag;
    logic [23:0] line_flush_addr;
    int bad_count, n_compared;

    icache_global_control icache_global_control_i (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .core_cache_enable,
        .core_cache_clear, .way_local_enable, .ramset1_local_enable, .ramset2_local_enable,
        .way_local_flush, .ramset1_local_flush, .ramset2_local_flush, .cache_active,
        .way_block_enable, .way_two_way, .ramset1_enable, .ramset2_enable,
        .miss_word_forward, .ram_fill_mode, .module_clock_enable, .auto_gate_active,
        .way_flush, .ramset1_flush, .ramset2_flush, .line_flush_req, .line_flush_addr,
        .line_flush_ack);
    core_model core_model_i (.aclk, .aresetn, .enable_req, .clear_req, .lag,
        .core_cache_enable, .core_cache_clear);

    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end

    task automatic stop_test();
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] dd, input logic [3:0] ss,
            input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        awaddr <= a;
        wdata <= dd;
        wstrb <= ss;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready) begin
                aw_done = 1'h1;
                awvalid <= 1'h0;
            end
            if (!w_done && wready) begin
                w_done = 1'h1;
                wvalid <= 1'h0;
            end
        end
        bready <= 1'h1;
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk(32'(bresp), 32'(er), "write response");
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        rready <= 1'h1;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rready <= 1'h0;
        chk(rdata, ed, "read data");
        chk(32'(rresp), 32'(er), "read response");
    endtask

    task automatic check_out();
        logic [7:0] got, exp;
        logic en;
        en = enable_req;
        got = {way_block_enable, ramset1_enable, ramset2_enable, way_two_way,
            miss_word_forward, ram_fill_mode, module_clock_enable, auto_gate_active};
        exp = {en & g_m[9] & (g_m[0] | way_local_enable),
            en & g_m[10] & (g_m[0] | ramset1_local_enable),
            en & g_m[10] & g_m[5] & (g_m[0] | ramset2_local_enable), g_m[3], g_m[2], g_m[1],
            en ? (!g_m[14] | cache_active) : g_m[15], en & g_m[14]};
        chk(32'(got), 32'(exp), "block outputs");
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        stop_test();
    end

    initial begin
        aresetn = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready, enable_req, clear_req} = 7'h0;
        {awaddr, araddr, wdata, wstrb, lag, line_flush_ack, cache_active} = 72'h0;
        {way_local_enable, ramset1_local_enable, ramset2_local_enable} = 3'h0;
        {way_local_flush, ramset1_local_flush, ramset2_local_flush} = 3'h0;
        g_m = 16'hc006;
        void'($urandom(91));
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(cgc_pkg::CTL_ADDR, 32'h0000_c006, cgc_pkg::RESP_OKAY);
        check_out();
        wr(16'h5020, $urandom, 4'hf, cgc_pkg::RESP_SLVERR);
        rd(16'h5020, 32'h0000_0000, cgc_pkg::RESP_SLVERR);
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 32'h0000_ce2f : $urandom;
            d[13:12] = 2'h0;
            s = (i == 0) ? 4'hf : 4'($urandom);
            wr(cgc_pkg::CTL_ADDR, d, s, cgc_pkg::RESP_OKAY);
            m = {{8{s[1]}}, {8{s[0]}}};
            g_m = (g_m & ~m) | (d[15:0] & m);
            {way_local_enable, ramset1_local_enable, ramset2_local_enable} <= 3'($urandom);
            {way_local_flush, ramset1_local_flush, ramset2_local_flush} <= 3'($urandom);
            cache_active <= 1'($urandom);
            lag <= 2'($urandom);
            enable_req <= i[0];
            repeat (5) @(posedge aclk);
            check_out();
            rd(cgc_pkg::CTL_ADDR, {16'h0000, g_m}, cgc_pkg::RESP_OKAY);
            clear_req <= 1'h1;
            @(posedge aclk);
            clear_req <= 1'h0;
            do @(posedge aclk); while (core_cache_clear !== 1'h1);
            @(posedge aclk);
            chk(32'({way_flush, ramset1_flush, ramset2_flush}), 32'({3{g_m[11]}} |
                {way_local_flush, ramset1_local_flush, ramset2_local_flush}), "flush");
            @(posedge aclk);
            chk(32'({way_flush, ramset1_flush, ramset2_flush}), 32'h0, "flush end");
            enable_req <= 1'h0;
            repeat (4) @(posedge aclk);
        end
        d = $urandom;
        wr(cgc_pkg::FAL_ADDR, d, 4'hf, cgc_pkg::RESP_OKAY);
        wr(cgc_pkg::FAH_ADDR, d >> 16, 4'hf, cgc_pkg::RESP_OKAY);
        rd(cgc_pkg::FAH_ADDR, 32'(d[31:16] & cgc_pkg::FAH_MASK), cgc_pkg::RESP_OKAY);
        g_m[12] = 1'h1;
        wr(cgc_pkg::CTL_ADDR, {16'h0000, g_m}, 4'h3, cgc_pkg::RESP_OKAY);
        do @(posedge aclk); while (line_flush_req !== 1'h1);
        chk(32'(line_flush_addr), 32'(d[23:0]), "line address");
        repeat (1 + $urandom % 4) @(posedge aclk);
        line_flush_ack <= 1'h1;
        @(posedge aclk);
        line_flush_ack <= 1'h0;
        g_m[12] = 1'h0;
        repeat (2) @(posedge aclk);
        chk(32'(line_flush_req), 32'h0, "line request");
        rd(cgc_pkg::CTL_ADDR, {16'h0000, g_m}, cgc_pkg::RESP_OKAY);
        stop_test();
    end
endmodule
`default_nettype wire
